// ==== sjlpg_pkg.sv ====
// shared constants and types for the jerk-limited step-rate profile generator
// Summary of operation
// R1: nonzero jerk setting ramps acceleration gradually, giving an S-shaped speed curve.
// R2: with jerk, acceleration rises, may hold at the programmed value, then ramps down.
// R3: physical jerk is the jerk setting divided by 100 times programmed acceleration.
// R4: jerk setting is a scaled integer below sixteen bits, not steps per s cubed.
// R5: deceleration uses the same jerk scaling with the programmed deceleration.
// R6: zero jerk gives constant acceleration, speed changes linearly.
// R7: trapezoid runs at programmed speed for steps left after both ramps.
// R8: larger jerk lengthens the constant-acceleration part, smaller shortens it.
// R9: accel and decel settings are steps/s per ms, one unit is 1000 steps/s^2.
// R10: if ramps exceed travel, deceleration starts before programmed speed is reached.
// R11: S-curve phases are symmetrical about the midpoint of the speed change.
// R12: decelerate when remaining steps equal braking distance; end on the final step.
// R13: start at starting speed and never command above programmed speed.
package sjlpg_pkg;
    localparam int     CLK_NS    = 40;
    localparam int     TICK_NS   = 1000000;
    localparam int     TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int     JERK_W    = 13;
    localparam int     JERK_MAX  = 5000;
    localparam int     JERK_DIV  = 100;
    localparam int     ACC_UNIT  = 1000;
    localparam longint SPD_SCALE = 100000;
    localparam longint POS_SCALE = 100000000;
    // scales chosen so every per-tick gain is an exact integer
    localparam longint ACC_K  = ACC_UNIT * SPD_SCALE * TICK_NS / 1000000000;
    localparam longint JRK_K  = ((ACC_UNIT / JERK_DIV) * SPD_SCALE * TICK_NS / 1000000000)
                                * TICK_NS / 1000000000;
    localparam longint POS_K  = POS_SCALE * TICK_NS / (SPD_SCALE * 1000000000);
    localparam longint BRK1_K = 2 * ACC_UNIT * SPD_SCALE * SPD_SCALE / POS_SCALE;
    localparam longint BRK2_K = JERK_DIV * POS_SCALE / (2 * SPD_SCALE);
    localparam int     SW = 44;
    localparam int     AW = 36;
    localparam int     PW = 56;
    localparam int     DW = 88;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ACCEL  = 8'h04;
    localparam logic [7:0] REG_DECEL  = 8'h08;
    localparam logic [7:0] REG_JERK   = 8'h0C;
    localparam logic [7:0] REG_VSTART = 8'h10;
    localparam logic [7:0] REG_VPROG  = 8'h14;
    localparam logic [7:0] REG_LEN    = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_SPEED  = 8'h20;
    localparam int         CTL_START  = 0;
    localparam logic [31:0] PARAM_RST = 32'h0;

    typedef enum logic [3:0] {
        S_IDLE   = 4'h0,
        S_JUP    = 4'h1,
        S_AHOLD  = 4'h2,
        S_JDN    = 4'h3,
        S_CRUISE = 4'h4,
        S_DUP    = 4'h5,
        S_DHOLD  = 4'h6,
        S_DDN    = 4'h7,
        S_CREEP  = 4'h8
    } sjlpg_state_t;
endpackage

// ==== sjlpg_div.sv ====
`timescale 1ns/1ns
// serial restoring divider, one quotient bit per clock
module sjlpg_div #(
    parameter int W = 88
) (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic         start,
    input  wire logic [W-1:0] num,
    input  wire logic [W-1:0] den,
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quo
);
    localparam int CW = $clog2(W + 1);
    logic [W-1:0]  rem_q;
    logic [W-1:0]  q_q;
    logic [W-1:0]  den_q;
    logic [CW-1:0] cnt_q;

    if (W < 2) begin : g_chk
        $error("divider width too small");
    end

    // a zero divisor yields all ones, callers gate it
    wire [W:0] sh  = {rem_q, q_q[W-1]};
    wire       ge  = sh >= {1'b0, den_q};
    wire [W:0] dif = sh - {1'b0, den_q};
    assign quo = q_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rem_q <= '0;
            q_q   <= '0;
            den_q <= '0;
            cnt_q <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_q <= '0;
                q_q   <= num;
                den_q <= den;
                cnt_q <= CW'(W);
                busy  <= 1'b1;
            end else if (busy) begin
                rem_q <= ge ? dif[W-1:0] : sh[W-1:0];
                q_q   <= {q_q[W-2:0], ge};
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == CW'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== sjlpg_top.sv ====
`timescale 1ns/1ns
// step-rate profile generator with its APB register file
module sjlpg_top
    import sjlpg_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic [23:0]      STEP_RATE,
    output logic             MOVING,
    output logic             MOVE_DONE
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    // the braking divisions must finish well inside one tick
    if (TICK_CYCLES < 4 * DW) begin : g_chk
        $error("tick period too short for the divider");
    end

    logic [15:0]       acc_set_q;
    logic [15:0]       dec_set_q;
    logic [JERK_W-1:0] jerk_q;
    logic [23:0]       vs_q;
    logic [23:0]       vp_q;
    logic [23:0]       len_q;
    logic              err_q;
    logic [TW-1:0]     tcnt_q;
    sjlpg_state_t      st_q;
    sjlpg_state_t      st_d;
    logic [AW-1:0]     ac_q;
    logic [AW-1:0]     ac_d;
    logic [SW-1:0]     sx_q;
    logic [SW-1:0]     sx_d;
    logic [SW-1:0]     gain_q;
    logic [SW-1:0]     gain_d;
    logic [PW-1:0]     pos_q;
    logic [PW-1:0]     pos_d;
    logic [PW-1:0]     b1_q;
    logic [PW-1:0]     b2_q;
    logic [1:0]        op_q;
    logic              go_q;
    logic              dv_busy;
    logic              dv_done;
    logic [DW-1:0]     dv_quo;
    logic [DW-1:0]     dv_num;
    logic [DW-1:0]     dv_den;
    logic [31:0]       rd_mux;

    // APB decode; one wait state so read data and error come from flops
    wire setup  = PSEL & PENABLE & ~PREADY;
    wire wr     = PSEL & PENABLE & PREADY & PWRITE;
    wire a_ctl  = PADDR == REG_CTRL;
    wire a_acc  = PADDR == REG_ACCEL;
    wire a_dec  = PADDR == REG_DECEL;
    wire a_jrk  = PADDR == REG_JERK;
    wire a_vs   = PADDR == REG_VSTART;
    wire a_vp   = PADDR == REG_VPROG;
    wire a_len  = PADDR == REG_LEN;
    wire a_sts  = PADDR == REG_STATUS;
    wire a_spd  = PADDR == REG_SPEED;
    wire mapped = a_ctl | a_acc | a_dec | a_jrk | a_vs | a_vp | a_len | a_sts | a_spd;
    assign rd_mux = a_acc ? 32'(acc_set_q) :
                    a_dec ? 32'(dec_set_q) :
                    a_jrk ? 32'(jerk_q) :
                    a_vs  ? 32'(vs_q) :
                    a_vp  ? 32'(vp_q) :
                    a_len ? 32'(len_q) :
                    a_sts ? 32'({err_q, st_q, MOVING}) :
                    a_spd ? 32'(STEP_RATE) : 32'h0;

    wire busy     = st_q != S_IDLE;
    wire jz       = jerk_q == '0;
    // out-of-range jerk is refused at start, never clipped
    wire prm_ok   = (acc_set_q != '0) & (dec_set_q != '0) & (32'(jerk_q) <= JERK_MAX)
                  & (vs_q != '0) & (vs_q <= vp_q) & (len_q != '0); // R4
    wire start_rq = wr & a_ctl & PWDATA[CTL_START];
    wire start_ok = start_rq & prm_ok & ~busy;
    wire tick     = tcnt_q == '0;

    // settings in steps/s per ms scaled to per-tick speed gains
    wire [SW-1:0] vpx  = SW'(vp_q * SPD_SCALE);
    wire [SW-1:0] vsx  = SW'(vs_q * SPD_SCALE);
    wire [AW-1:0] atgt = AW'(acc_set_q * ACC_K); // R9
    wire [AW-1:0] dtgt = AW'(dec_set_q * ACC_K); // R9
    wire [AW-1:0] jsa  = AW'(jerk_q * acc_set_q * JRK_K); // R3
    wire [AW-1:0] jsd  = AW'(jerk_q * dec_set_q * JRK_K); // R5
    wire [PW-1:0] lenx = PW'(len_q * POS_SCALE);

    wire          dec_ph = (st_q == S_DUP) | (st_q == S_DHOLD) | (st_q == S_DDN)
                         | (st_q == S_CREEP);
    wire [AW-1:0] js     = dec_ph ? jsd : jsa;
    wire [AW-1:0] tgt    = dec_ph ? dtgt : atgt;
    wire [AW:0]   ac_sum = {1'b0, ac_q} + {1'b0, js};
    wire [AW-1:0] ac_up  = (ac_sum >= {1'b0, tgt}) ? tgt : ac_sum[AW-1:0];
    // floor at one jerk step so a ramp-down never stalls short of its speed
    wire [AW-1:0] ac_dn  = (ac_q > js) ? ac_q - js : js;
    wire [SW:0]   sx_sum = {1'b0, sx_q} + {1'b0, SW'(ac_q)};
    wire [SW-1:0] sx_up  = (sx_sum >= {1'b0, vpx}) ? vpx : sx_sum[SW-1:0]; // R13
    wire [SW-1:0] sx_dn  = (sx_q <= vsx + SW'(ac_q)) ? vsx : sx_q - SW'(ac_q);
    wire [PW:0]   pos_nx = {1'b0, pos_q} + {1'b0, PW'(sx_q * POS_K)};
    wire          end_go = pos_nx >= {1'b0, lenx}; // R12
    wire [PW-1:0] b2_use = jz ? {PW{1'b0}} : b2_q;
    wire [PW+1:0] brk    = {2'b00, b1_q} + {2'b00, b2_use};
    wire          acc_ph = (st_q == S_JUP) | (st_q == S_AHOLD) | (st_q == S_JDN)
                         | (st_q == S_CRUISE);
    // braking distance covers the remaining travel: start slowing now
    wire          dec_go = acc_ph & ({2'b00, pos_q} + brk >= {2'b00, lenx}); // R10 R12

    always_comb begin
        st_d   = st_q;
        ac_d   = ac_q;
        sx_d   = sx_q;
        gain_d = gain_q;
        pos_d  = pos_q;
        if (start_ok) begin
            st_d   = jz ? S_AHOLD : S_JUP; // R6 R1
            ac_d   = jz ? atgt : '0; // R6
            sx_d   = vsx; // R13
            gain_d = '0;
            pos_d  = '0;
        end else if (tick && busy) begin
            pos_d = pos_nx[PW-1:0];
            if (end_go) begin
                st_d = S_IDLE; // R12
                ac_d = '0;
                sx_d = '0;
            end else if (dec_go) begin
                st_d   = jz ? S_DHOLD : S_DUP; // R10
                ac_d   = jz ? dtgt : '0; // R6
                gain_d = '0;
            end else begin
                case (st_q)
                    S_JUP: begin
                        ac_d   = ac_up; // R1 R2
                        gain_d = gain_q + SW'(ac_q);
                        sx_d   = sx_up;
                        // ramp down once the gap equals what the rise gained
                        if (sx_up == vpx) begin
                            st_d = S_CRUISE;
                            ac_d = '0;
                        end else if (vpx - sx_up <= gain_d) begin
                            st_d = S_JDN; // R11
                        end else if (ac_up == atgt) begin
                            st_d = S_AHOLD; // R2 R8
                        end
                    end
                    S_AHOLD: begin
                        sx_d = sx_up; // R6
                        if (sx_up == vpx) begin
                            st_d = S_CRUISE;
                            ac_d = '0;
                        end else if (!jz && vpx - sx_up <= gain_q) begin
                            st_d = S_JDN; // R8 R11
                        end
                    end
                    S_JDN: begin
                        ac_d = ac_dn; // R2
                        sx_d = sx_up;
                        if (sx_up == vpx) begin
                            st_d = S_CRUISE;
                            ac_d = '0;
                        end
                    end
                    S_CRUISE: begin
                        sx_d = vpx; // R7
                    end
                    S_DUP: begin
                        ac_d   = ac_up; // R5
                        gain_d = gain_q + SW'(ac_q);
                        sx_d   = sx_dn;
                        if (sx_dn == vsx) begin
                            st_d = S_CREEP;
                        end else if (sx_dn - vsx <= gain_d) begin
                            st_d = S_DDN; // R11
                        end else if (ac_up == dtgt) begin
                            st_d = S_DHOLD;
                        end
                    end
                    S_DHOLD: begin
                        sx_d = sx_dn;
                        if (sx_dn == vsx) begin
                            st_d = S_CREEP;
                        end else if (!jz && sx_dn - vsx <= gain_q) begin
                            st_d = S_DDN; // R11
                        end
                    end
                    S_DDN: begin
                        ac_d = ac_dn; // R5
                        sx_d = sx_dn;
                        if (sx_dn == vsx) begin
                            st_d = S_CREEP;
                        end
                    end
                    S_CREEP: begin
                        sx_d = vsx; // R12
                    end
                    default: begin
                        st_d = S_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q   <= S_IDLE;
            ac_q   <= '0;
            sx_q   <= '0;
            gain_q <= '0;
            pos_q  <= '0;
        end else begin
            st_q   <= st_d;
            ac_q   <= ac_d;
            sx_q   <= sx_d;
            gain_q <= gain_d;
            pos_q  <= pos_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || start_ok) begin
            tcnt_q <= TW'(TICK_CYCLES - 1);
        end else begin
            tcnt_q <= tick ? TW'(TICK_CYCLES - 1) : tcnt_q - 1'b1;
        end
    end

    // settings are frozen while a move runs
    always_ff @(posedge CLK) begin
        if (RST) begin
            acc_set_q <= 16'(PARAM_RST);
            dec_set_q <= 16'(PARAM_RST);
            jerk_q    <= JERK_W'(PARAM_RST);
            vs_q      <= 24'(PARAM_RST);
            vp_q      <= 24'(PARAM_RST);
            len_q     <= 24'(PARAM_RST);
            err_q     <= 1'b0;
        end else begin
            if (wr && !busy) begin
                if (a_acc) acc_set_q <= PWDATA[15:0];
                if (a_dec) dec_set_q <= PWDATA[15:0];
                if (a_jrk) jerk_q <= PWDATA[JERK_W-1:0]; // R4
                if (a_vs) vs_q <= PWDATA[23:0];
                if (a_vp) vp_q <= PWDATA[23:0];
                if (a_len) len_q <= PWDATA[23:0];
            end
            if (start_rq) err_q <= ~start_ok;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup;
            if (setup) begin
                PRDATA  <= PWRITE ? 32'h0 : rd_mux;
                PSLVERR <= ~mapped;
            end
        end
    end

    // braking distance pieces and output rate, recomputed round robin
    assign dv_num = (op_q == 2'd0) ? DW'(sx_q) * DW'(sx_q) - DW'(vsx) * DW'(vsx) :
                    (op_q == 2'd1) ? DW'(({1'b0, sx_q} + {1'b0, vsx}) * BRK2_K) :
                    DW'(sx_q);
    assign dv_den = (op_q == 2'd0) ? DW'(dec_set_q * BRK1_K) : // R5
                    (op_q == 2'd1) ? DW'(jerk_q) : DW'(SPD_SCALE);

    sjlpg_div #(.W(DW)) u_div (
        .CLK   (CLK),
        .RST   (RST),
        .start (go_q),
        .num   (dv_num),
        .den   (dv_den),
        .busy  (dv_busy),
        .done  (dv_done),
        .quo   (dv_quo)
    );

    wire          q_ovf = dv_quo[DW-1:PW] != '0;
    wire [PW-1:0] q_sat = q_ovf ? '1 : dv_quo[PW-1:0];

    always_ff @(posedge CLK) begin
        if (RST) begin
            op_q      <= 2'd0;
            go_q      <= 1'b1;
            b1_q      <= '0;
            b2_q      <= '0;
            STEP_RATE <= 24'h0;
            MOVING    <= 1'b0;
            MOVE_DONE <= 1'b0;
        end else begin
            go_q      <= dv_done;
            MOVING    <= st_d != S_IDLE;
            MOVE_DONE <= tick & busy & end_go & ~start_ok; // R12
            if (dv_done) begin
                op_q <= (op_q == 2'd2) ? 2'd0 : op_q + 2'd1;
                if (op_q == 2'd0) b1_q <= sx_q < vsx ? '0 : q_sat;
                if (op_q == 2'd1) b2_q <= q_sat;
                if (op_q == 2'd2) STEP_RATE <= busy ? 24'(q_sat) : 24'h0;
            end
            if (st_d == S_IDLE) STEP_RATE <= 24'h0;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_r13_cap;
        busy |-> sx_q <= vpx && sx_q >= vsx;
    endproperty
    a_r13_cap: assert property (p_r13_cap) else $error("speed outside start..programmed"); // R13

    property p_r4_range;
        $rose(busy) |-> 32'(jerk_q) <= 5000 && sx_q == vsx;
    endproperty
    a_r4_range: assert property (p_r4_range) else $error("move started with bad jerk"); // R4

    property p_r3_rise;
        tick && st_q == S_JUP && !dec_go && !end_go && sx_up != vpx
            && ac_sum < {1'b0, atgt}
        |=> ac_q == $past(ac_q) + AW'(jerk_q * acc_set_q);
    endproperty
    a_r3_rise: assert property (p_r3_rise) else $error("jerk step not setting*accel"); // R3

    property p_r5_fall;
        tick && st_q == S_DUP && !end_go && sx_dn != vsx && ac_sum < {1'b0, dtgt}
        |=> ac_q == $past(ac_q) + AW'(jerk_q * dec_set_q);
    endproperty
    a_r5_fall: assert property (p_r5_fall) else $error("decel jerk step wrong"); // R5

    property p_r9_const;
        $rose(busy) && jz |-> ac_q == AW'(acc_set_q) * AW'(100000);
    endproperty
    a_r9_const: assert property (p_r9_const) else $error("accel unit scaling wrong"); // R9

    property p_r6_linear;
        tick && st_q == S_AHOLD && jz && !dec_go && !end_go && sx_sum < {1'b0, vpx}
        |=> sx_q - $past(sx_q) == SW'(acc_set_q) * SW'(100000);
    endproperty
    a_r6_linear: assert property (p_r6_linear) else $error("speed not linear"); // R6

    property p_r2_hold;
        st_q == S_AHOLD && !jz |-> ac_q == atgt;
    endproperty
    a_r2_hold: assert property (p_r2_hold) else $error("hold not at programmed accel"); // R2

    property p_r7_cruise;
        tick && st_q == S_CRUISE && !dec_go && !end_go |=> st_q == S_CRUISE && sx_q == vpx;
    endproperty
    a_r7_cruise: assert property (p_r7_cruise) else $error("left cruise early"); // R7

    property p_r10_brake;
        tick && dec_go && !end_go |=> st_q == S_DUP || st_q == S_DHOLD;
    endproperty
    a_r10_brake: assert property (p_r10_brake) else $error("braking not entered"); // R10

    property p_r12_end;
        tick && busy && end_go |=> !busy && MOVE_DONE ##1 !MOVE_DONE && STEP_RATE == 24'h0;
    endproperty
    a_r12_end: assert property (p_r12_end) else $error("move did not end cleanly"); // R12

    c_trap: cover property (st_q == S_AHOLD && !jz ##1 st_q == S_JDN);
    c_tri: cover property (st_q == S_JUP ##1 st_q == S_JDN);
    c_creep: cover property (st_q == S_CREEP ##1 st_q == S_IDLE);
endmodule

// ==== sjlpg_host.sv ====
`timescale 1ns/1ns
// host model: apb master that hands move settings to the profile generator
module sjlpg_host (
    input  wire logic        CLK,
    input  wire logic        PREADY,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PSLVERR,
    output logic             PSEL,
    output logic             PENABLE,
    output logic             PWRITE,
    output logic [7:0]       PADDR,
    output logic [31:0]      PWDATA
);
    initial begin
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
    end

    // callers pass jerk below 16 bits, except one all-ones width probe, and accel in steps/s per ms
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // released lines flip so stale values cannot pass for a match
        PADDR <= ~a;
        PWDATA <= ~d;
    endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
// self-checking bench for the step-rate profile generator
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    $display("Error t=%0t got %h exp %h", $time, (got), (exp)); n_errors++; end end
module tb;
    import sjlpg_pkg::*;
    localparam int TK = 400; // short tick, profile math still per tick
    logic        CLK;
    logic        RST;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [23:0] STEP_RATE;
    logic        MOVING;
    logic        MOVE_DONE;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t0 = 0;

    sjlpg_top #(.TICK_CYCLES(TK)) sjlpg_top_i (.CLK(CLK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STEP_RATE(STEP_RATE),
        .MOVING(MOVING), .MOVE_DONE(MOVE_DONE));
    sjlpg_host host_i (.CLK(CLK), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));

    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK) cyc <= cyc + 1;

    task automatic step();
        @(posedge CLK);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        host_i.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
        host_i.xfer(1'b0, a, 32'h0, r, e);
    endtask
    // load settings, request a start, note when the move began
    task automatic go(input int ac, input int dc, input int j, input int vs, input int vp,
                      input int ln);
        int n;
        wr(REG_ACCEL, 32'(ac));
        wr(REG_DECEL, 32'(dc));
        wr(REG_JERK, 32'(j));
        wr(REG_VSTART, 32'(vs));
        wr(REG_VPROG, 32'(vp));
        wr(REG_LEN, 32'(ln));
        wr(REG_CTRL, 32'h1);
        n = 0;
        while (MOVING !== 1'b1 && n < 4) begin
            step();
            n++;
        end
        t0 = cyc;
    endtask
    task automatic at(input int k);
        while (cyc < t0 + k * TK + 380) step();
    endtask
    task automatic wait_done(output int tk, output logic [23:0] pk);
        int n;
        pk = 24'h0;
        n = 0;
        while (MOVE_DONE !== 1'b1 && n < 60000) begin
            step();
            n++;
            if (STEP_RATE > pk) pk = STEP_RATE;
        end
        `CHK(MOVE_DONE, 1'b1)
        `CHK(STEP_RATE, 24'h0)
        `CHK(MOVING, 1'b0)
        tk = (cyc - t0) / TK;
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 9; i++) begin
            rd(8'(4 * i), r, e);
            `CHK(r, 32'h0)
        end
        rd(8'h24, r, e);
        `CHK(e, 1'b1)
        wr(REG_JERK, 32'hFFFFFFFF);
        rd(REG_JERK, r, e);
        `CHK(r, 32'h00001FFF)
        wr(REG_CTRL, 32'h1);
        rd(REG_STATUS, r, e);
        `CHK(r[5], 1'b1)
    endtask
    task automatic t_range();
        logic [31:0] r;
        logic        e;
        go(1000, 1000, 5001, 10000, 20000, 600);
        rd(REG_STATUS, r, e);
        `CHK(r[5], 1'b1)
        `CHK(MOVING, 1'b0)
    endtask
    // zero jerk: each 400-cycle tick adds the setting as steps/s
    task automatic t_linear();
        logic [31:0] r;
        logic        e;
        int          tk;
        logic [23:0] pk;
        go(1000, 1000, 0, 10000, 20000, 600);
        for (int k = 0; k < 4; k++) begin
            at(k);
            `CHK(STEP_RATE, 24'(10000 + 1000 * k))
        end
        wr(REG_VPROG, 32'h5);
        wr(REG_CTRL, 32'h1);
        rd(REG_VPROG, r, e);
        `CHK(r, 32'(20000))
        rd(REG_STATUS, r, e);
        `CHK(r[0], 1'b1)
        wait_done(tk, pk);
        `CHK(pk, 24'(20000))
        `CHK((tk >= 30 && tk <= 42), 1'b1)
    endtask
    // ramps too long for the travel: peak stays near 15811 steps/s
    task automatic t_tri();
        int          tk;
        logic [23:0] pk;
        go(1000, 1000, 0, 10000, 20000, 150);
        wait_done(tk, pk);
        `CHK((pk < 24'(20000) && pk > 24'(14000)), 1'b1)
    endtask
    // jerk 5000 is 50a: accel grows 20 steps/s per tick, not 400
    // full accel after 20 ticks with 6200 left to gain, so it holds: trapezoid phase
    task automatic t_scurve();
        logic [23:0] s[4];
        int          tk;
        logic [23:0] pk;
        go(400, 400, 5000, 10000, 20000, 1500);
        for (int k = 0; k < 4; k++) begin
            at(k);
            s[k] = STEP_RATE;
        end
        `CHK(s[0], 24'(10000))
        `CHK((s[1] - s[0] < 24'(250)), 1'b1)
        `CHK((s[2] - s[1] > s[1] - s[0]), 1'b1)
        `CHK((s[3] - s[2] > s[2] - s[1]), 1'b1)
        wait_done(tk, pk);
        `CHK((pk <= 24'(20000) && pk >= 24'(19000)), 1'b1)
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        RST = 1'b1;
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        t_reset();
        t_range();
        t_linear();
        t_tri();
        t_scurve();
        results();
    end
    // whole sequence needs roughly 60000 cycles
    initial begin
        repeat (100000) @(posedge CLK);
        n_errors++;
        results();
    end
endmodule
